// file: hw/cmcs_div_if.sv
// Interface between the selection control and the clock divider
interface cmcs_div_if;
    import cmcs_pkg::*;

    cmcs_code_t req_code;
    logic       user_en;
    logic       mclk;
    logic       user_clk;
    cmcs_code_t cur_code;

    modport ctrl (
        output req_code,
        output user_en,
        input  mclk,
        input  user_clk,
        input  cur_code
    );

    modport div (
        input  req_code,
        input  user_en,
        output mclk,
        output user_clk,
        output cur_code
    );
endinterface : cmcs_div_if

// file: hw/cmcs_divider.sv
// Free-running oscillator divider that changes rate only at period boundaries
`include "cmcs_params.svh"

module cmcs_divider
    import cmcs_pkg::*;
(
    input  wire logic CLK_SYS,
    input  wire logic RESETN,
    cmcs_div_if.div   dv
);

    cmcs_cnt_t  cnt_r,   cnt_nxt;
    logic       clk_r,   clk_nxt;
    logic       usr_r,   usr_nxt;
    logic       uen_r,   uen_nxt;
    cmcs_code_t code_r,  code_nxt;

    // ------------------------------------------------------------------------
    // Next state: a new rate or user gate is taken only when a low phase ends,
    // so no high or low phase is ever cut short
    // ------------------------------------------------------------------------
    always_comb begin
        cnt_nxt  = cnt_r - `CMCS_CNT_ONE;
        clk_nxt  = clk_r;
        code_nxt = code_r;
        uen_nxt  = uen_r;
        if (cnt_r == `CMCS_CNT_ONE) begin
            clk_nxt = ~clk_r;
            if (!clk_r) begin
                code_nxt = dv.req_code;
                uen_nxt  = dv.user_en;                   // Gate changes on period edge
                cnt_nxt  = cmcs_half(dv.req_code);
            end else begin
                cnt_nxt  = cmcs_half(code_r);
            end
        end
        usr_nxt = clk_nxt & uen_nxt;
    end

    // Registers; never stops, whatever the configuration state
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            cnt_r  <= `CMCS_HALF_3M1;
            clk_r  <= `CMCS_RST_LOW;
            usr_r  <= `CMCS_RST_LOW;
            uen_r  <= `CMCS_RST_LOW;
            code_r <= `CMCS_CODE_HW_3M1;
        end else begin
            cnt_r  <= cnt_nxt;
            clk_r  <= clk_nxt;
            usr_r  <= usr_nxt;
            uen_r  <= uen_nxt;
            code_r <= code_nxt;
        end
    end

    assign dv.mclk     = clk_r;
    assign dv.user_clk = usr_r;
    assign dv.cur_code = code_r;

endmodule : cmcs_divider

// file: hw/cmcs_params.svh
// Constant macros for the configuration master clock selection block
`ifndef CMCS_PARAMS_SVH
`define CMCS_PARAMS_SVH

// ----------------------------------------------------------------------------
// Frequency selection codes (nominal MHz in the name)
// ----------------------------------------------------------------------------
`define CMCS_CODE_2M5      4'h0
`define CMCS_CODE_4M3      4'h1
`define CMCS_CODE_5M4      4'h2
`define CMCS_CODE_6M9      4'h3
`define CMCS_CODE_8M1      4'h4
`define CMCS_CODE_9M2      4'h5
`define CMCS_CODE_10M      4'h6
`define CMCS_CODE_13M      4'h7
`define CMCS_CODE_15M      4'h8
`define CMCS_CODE_20M      4'h9
`define CMCS_CODE_26M      4'hA
`define CMCS_CODE_33M      4'hB
`define CMCS_CODE_HW_3M1   4'hC
`define CMCS_CODE_SW_DFLT  `CMCS_CODE_2M5
`define CMCS_CODE_MAX_ENC  `CMCS_CODE_15M
`define CMCS_CODE_MAX_PLN  `CMCS_CODE_33M

// ----------------------------------------------------------------------------
// Half-period lengths in system clock cycles (scaled model of the oscillator)
// ----------------------------------------------------------------------------
`define CMCS_HALF_2M5      5'h10
`define CMCS_HALF_3M1      5'h0D
`define CMCS_HALF_4M3      5'h09
`define CMCS_HALF_5M4      5'h07
`define CMCS_HALF_6M9      5'h06
`define CMCS_HALF_8M1      5'h05
`define CMCS_HALF_9M2      5'h04
`define CMCS_HALF_10M      5'h04
`define CMCS_HALF_13M      5'h03
`define CMCS_HALF_15M      5'h03
`define CMCS_HALF_20M      5'h02
`define CMCS_HALF_26M      5'h02
`define CMCS_HALF_33M      5'h01
`define CMCS_CNT_ONE       5'h01
`define CMCS_CNT_ZERO      5'h00

// ----------------------------------------------------------------------------
// Port selection and reset values
// ----------------------------------------------------------------------------
`define CMCS_PORT_NONE     2'h0
`define CMCS_RST_LOW       1'h0

`endif

// file: hw/cmcs_pkg.sv
// Types and helper functions for the configuration master clock selection block
`include "cmcs_params.svh"

package cmcs_pkg;

    typedef logic [3:0] cmcs_code_t;
    typedef logic [4:0] cmcs_cnt_t;
    typedef logic [1:0] cmcs_port_t;

    // ------------------------------------------------------------------------
    // Configuration cycle states
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        CMCS_IDLE   = 3'h1,
        CMCS_LOCKED = 3'h2,
        CMCS_DONE   = 3'h4
    } cmcs_state_e;

    // Half-period length for a selection code
    function automatic cmcs_cnt_t cmcs_half(input cmcs_code_t code);
        case (code)
            `CMCS_CODE_2M5:    cmcs_half = `CMCS_HALF_2M5;
            `CMCS_CODE_4M3:    cmcs_half = `CMCS_HALF_4M3;
            `CMCS_CODE_5M4:    cmcs_half = `CMCS_HALF_5M4;
            `CMCS_CODE_6M9:    cmcs_half = `CMCS_HALF_6M9;
            `CMCS_CODE_8M1:    cmcs_half = `CMCS_HALF_8M1;
            `CMCS_CODE_9M2:    cmcs_half = `CMCS_HALF_9M2;
            `CMCS_CODE_10M:    cmcs_half = `CMCS_HALF_10M;
            `CMCS_CODE_13M:    cmcs_half = `CMCS_HALF_13M;
            `CMCS_CODE_15M:    cmcs_half = `CMCS_HALF_15M;
            `CMCS_CODE_20M:    cmcs_half = `CMCS_HALF_20M;
            `CMCS_CODE_26M:    cmcs_half = `CMCS_HALF_26M;
            `CMCS_CODE_33M:    cmcs_half = `CMCS_HALF_33M;
            default:           cmcs_half = `CMCS_HALF_3M1;
        endcase
    endfunction : cmcs_half

    // Whether a requested code may be taken under the encryption setting
    function automatic logic cmcs_code_ok(input cmcs_code_t code, input logic encrypted);
        if (encrypted) begin
            cmcs_code_ok = (code <= `CMCS_CODE_MAX_ENC);
        end else begin
            cmcs_code_ok = (code <= `CMCS_CODE_MAX_PLN);
        end
    endfunction : cmcs_code_ok

endpackage : cmcs_pkg

// file: hw/cmcs_top.sv
// Configuration master clock selection and configuration port hold logic

// How it works
// The master clock is a divided copy of the system clock that stands in
// for the free-running oscillator; it counts from the end of reset and
// no input can stop it.
// Clock bits from the bitstream only stage a new rate. The divider takes
// the staged rate at the end of a low phase, so a rate change never cuts
// a high or low phase short.
// The configuration port is latched on the synchronised start edge and
// held until the done strobe; pins and starts are ignored meanwhile.
// A scan port activation is remembered until the next power-up reset.
// Limitation: a code outside the table, or too fast for encryption, is
// refused and flagged, never clipped to the nearest legal rate.

`include "cmcs_params.svh"

module cmcs_top
    import cmcs_pkg::*;
(
    input  wire logic       CLK_SYS,
    input  wire logic       RESETN,
    input  wire logic [1:0] CFG_PORT_PINS,
    input  wire logic       CFG_START_PIN,
    input  wire logic       CFG_DONE,
    input  wire logic       CLK_BITS_VALID,
    input  wire logic [3:0] CLK_BITS_CODE,
    input  wire logic       ENCRYPT_EN,
    input  wire logic       TAP_ACTIVATE,
    input  wire logic       USER_OSC_EN,
    output logic            CONFIG_MASTER_CLOCK,
    output logic            USER_OSC_CLK,
    output logic [3:0]      CLOCK_CODE,
    output logic            CLOCK_CODE_REJECT,
    output logic [1:0]      ACTIVE_PORT,
    output logic            PORT_HELD,
    output logic            TAP_ACTIVE
);

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    cmcs_port_t  port_s1_r, port_s2_r;
    logic        start_s1_r, start_s2_r;

    // Two flops per pin; only the second stage feeds any logic
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            port_s1_r  <= `CMCS_PORT_NONE;
            port_s2_r  <= `CMCS_PORT_NONE;
            start_s1_r <= `CMCS_RST_LOW;
            start_s2_r <= `CMCS_RST_LOW;
        end else begin
            port_s1_r  <= CFG_PORT_PINS;
            port_s2_r  <= port_s1_r;
            start_s1_r <= CFG_START_PIN;
            start_s2_r <= start_s1_r;
        end
    end

    // ------------------------------------------------------------------------
    // Start edge detector
    // ------------------------------------------------------------------------
    logic        start_d_r;
    logic        start_rise;

    // Delay of the synchronised start; it resets low like the idle pin,
    // so no false start edge follows a reset
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            start_d_r <= `CMCS_RST_LOW;
        end else begin
            start_d_r <= start_s2_r;
        end
    end

    // One-cycle strobe on the rising edge of the start pin
    assign start_rise = start_s2_r & ~start_d_r;

    // ------------------------------------------------------------------------
    // Configuration port hold
    // ------------------------------------------------------------------------
    cmcs_state_e state_r, state_nxt;
    cmcs_port_t  port_r,  port_nxt;
    logic        held_r,  held_nxt;

    // Port pins are ignored while a cycle is running, so a pin glitch cannot
    // move configuration to another port halfway through
    always_comb begin
        state_nxt = state_r;
        port_nxt  = port_r;
        held_nxt  = held_r;
        case (state_r)
            CMCS_IDLE, CMCS_DONE: begin
                if (start_rise) begin
                    state_nxt = CMCS_LOCKED;
                    port_nxt  = port_s2_r;
                    held_nxt  = 1'h1;
                end
            end
            CMCS_LOCKED: begin
                // Start edges and pin changes are ignored until done
                if (CFG_DONE) begin
                    state_nxt = CMCS_DONE;
                    held_nxt  = 1'h0;
                end
            end
            default: begin
                // Illegal encodings recover to idle with no port held
                state_nxt = CMCS_IDLE;
                port_nxt  = `CMCS_PORT_NONE;
                held_nxt  = 1'h0;
            end
        endcase
    end

    // Port hold registers
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            state_r <= CMCS_IDLE;
            port_r  <= `CMCS_PORT_NONE;
            held_r  <= `CMCS_RST_LOW;
        end else begin
            state_r <= state_nxt;
            port_r  <= port_nxt;
            held_r  <= held_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Boundary-scan activation
    // ------------------------------------------------------------------------
    logic        tap_r,   tap_nxt;

    // Sticky once the scan port is opened; only a power-up reset clears it,
    // so a later configuration cycle cannot take the port away
    always_comb begin
        tap_nxt = tap_r | TAP_ACTIVATE;
    end

    // Scan activation register
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            tap_r <= `CMCS_RST_LOW;
        end else begin
            tap_r <= tap_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Frequency choice from the bitstream
    // ------------------------------------------------------------------------
    // Staged code resets to the hardware default rate
    cmcs_code_t req_r, req_nxt;
    logic       rej_r, rej_nxt;
    logic       code_ok;

    // Out-of-set or too-fast codes keep the current rate; the source is meant
    // never to send them, so a reject only flags a bad bitstream
    always_comb begin
        code_ok = cmcs_code_ok(CLK_BITS_CODE, ENCRYPT_EN);
        req_nxt = req_r;
        rej_nxt = rej_r;
        if (CLK_BITS_VALID) begin
            if (code_ok) begin
                req_nxt = CLK_BITS_CODE;
                rej_nxt = 1'h0;
            end else begin
                rej_nxt = 1'h1;
            end
        end
    end

    // Choice registers
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            req_r <= `CMCS_CODE_HW_3M1;
            rej_r <= `CMCS_RST_LOW;
        end else begin
            req_r <= req_nxt;
            rej_r <= rej_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------------------
    cmcs_div_if div_bus ();

    // Staged rate and user gate; the divider takes both at a period edge
    assign div_bus.req_code = req_r;
    assign div_bus.user_en  = USER_OSC_EN;

    // Divider runs from the end of reset on; nothing here can stop it
    cmcs_divider u_div (
        .CLK_SYS (CLK_SYS),
        .RESETN  (RESETN),
        .dv      (div_bus.div)
    );

    // ------------------------------------------------------------------------
    // Outputs, all from flops
    // ------------------------------------------------------------------------
    // Clock side, straight from the divider registers
    assign CONFIG_MASTER_CLOCK = div_bus.mclk;
    assign USER_OSC_CLK        = div_bus.user_clk;
    assign CLOCK_CODE          = div_bus.cur_code;

    // Status side
    assign CLOCK_CODE_REJECT   = rej_r;
    assign ACTIVE_PORT         = port_r;
    assign PORT_HELD           = held_r;
    assign TAP_ACTIVE          = tap_r;

endmodule : cmcs_top

// file: testbench/cmcs_assertions.sv
// Port-level checks for the master clock selection top
module cmcs_chk (
    input wire logic       CLK_SYS,
    input wire logic       RESETN,
    input wire logic       CFG_DONE,
    input wire logic       CLK_BITS_VALID,
    input wire logic [3:0] CLK_BITS_CODE,
    input wire logic       ENCRYPT_EN,
    input wire logic       TAP_ACTIVATE,
    input wire logic       CONFIG_MASTER_CLOCK,
    input wire logic       USER_OSC_CLK,
    input wire logic [3:0] CLOCK_CODE,
    input wire logic       CLOCK_CODE_REJECT,
    input wire logic [1:0] ACTIVE_PORT,
    input wire logic       PORT_HELD,
    input wire logic       TAP_ACTIVE
);
    timeunit 1ns;
    timeprecision 1ns;
    // Half periods per code, last entry is the power-up default
    localparam logic [4:0] HALF [0:12] = '{5'h10, 5'h09, 5'h07, 5'h06, 5'h05, 5'h04, 5'h04,
                                           5'h03, 5'h03, 5'h02, 5'h02, 5'h01, 5'h0D};
    logic [3:0] last_good_r;
    logic       prev_r;
    logic [5:0] ph_r;
    logic       ok;
    assign ok = (CLK_BITS_CODE <= 4'hB) && !(ENCRYPT_EN && CLK_BITS_CODE > 4'h8);
    // Shadow of the last accepted code and a phase length counter
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            last_good_r <= 4'hC;
            prev_r      <= 1'b0;
            ph_r        <= 6'h00;
        end else begin
            if (CLK_BITS_VALID && ok) begin
                last_good_r <= CLK_BITS_CODE;
            end
            prev_r <= CONFIG_MASTER_CLOCK;
            ph_r   <= (CONFIG_MASTER_CLOCK != prev_r) ? 6'h01 : ph_r + 6'h01;
        end
    end
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);
    chk_clock_runs: assert property (##[1:33] (CONFIG_MASTER_CLOCK != prev_r))
        else $error("master clock stalled");
    chk_code_track: assert property ($rose(CONFIG_MASTER_CLOCK) |-> CLOCK_CODE == $past(last_good_r))
        else $error("clock code not the last accepted one");
    chk_sw_default: assert property ($rose(CONFIG_MASTER_CLOCK) && CLOCK_CODE == 4'h0 |->
        ##15 CONFIG_MASTER_CLOCK ##1 !CONFIG_MASTER_CLOCK)
        else $error("default rate high phase wrong");
    chk_phase_len: assert property (CONFIG_MASTER_CLOCK != prev_r |-> ph_r == {1'b0, HALF[$past(CLOCK_CODE)]})
        else $error("clock phase length wrong");
    chk_code_reject: assert property (CLK_BITS_VALID && !ok |=> CLOCK_CODE_REJECT)
        else $error("illegal code not rejected");
    chk_user_gate: assert property (USER_OSC_CLK |-> CONFIG_MASTER_CLOCK)
        else $error("user clock out of phase");
    chk_port_hold: assert property (PORT_HELD && !CFG_DONE |=> PORT_HELD && $stable(ACTIVE_PORT))
        else $error("port dropped mid cycle");
    chk_port_release: assert property (PORT_HELD && CFG_DONE |=> !PORT_HELD)
        else $error("port not released");
    chk_tap_sticky: assert property (TAP_ACTIVATE || TAP_ACTIVE |=> TAP_ACTIVE)
        else $error("scan port not active");
    cov_default: cover property ($rose(CONFIG_MASTER_CLOCK) && CLOCK_CODE == 4'h0);
    cov_release: cover property (PORT_HELD && CFG_DONE);
    cov_tap: cover property (TAP_ACTIVATE);
endmodule : cmcs_chk

bind cmcs_top cmcs_chk u_cmcs_chk (
    .CLK_SYS(CLK_SYS), .RESETN(RESETN), .CFG_DONE(CFG_DONE), .CLK_BITS_VALID(CLK_BITS_VALID),
    .CLK_BITS_CODE(CLK_BITS_CODE), .ENCRYPT_EN(ENCRYPT_EN), .TAP_ACTIVATE(TAP_ACTIVATE),
    .CONFIG_MASTER_CLOCK(CONFIG_MASTER_CLOCK), .USER_OSC_CLK(USER_OSC_CLK), .CLOCK_CODE(CLOCK_CODE),
    .CLOCK_CODE_REJECT(CLOCK_CODE_REJECT), .ACTIVE_PORT(ACTIVE_PORT), .PORT_HELD(PORT_HELD),
    .TAP_ACTIVE(TAP_ACTIVE));

// file: testbench/cmcs_cfg_src.sv
// Model of the bitstream source: start, clock bits, done and encryption
module cmcs_cfg_src (
    input  wire logic clk_sys,
    output logic       start_pin,
    output logic       done,
    output logic       bits_valid,
    output logic [3:0] bits_code,
    output logic       enc
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle levels at time zero
    initial begin
        start_pin = 1'b0;
        done = 1'b0;
        bits_valid = 1'b0;
        bits_code = 4'h5;
        enc = 1'b0;
    end
    // One clock-bits word; bad_ok lets a scenario break the limits
    task automatic send_bits(input logic [3:0] code, input bit bad_ok);
        logic [3:0] c;
        c = code;
        if (!bad_ok && enc && c > 4'h8) c = 4'h8;
        if (!bad_ok && c > 4'hB) c = 4'hB;
        @(posedge clk_sys); #10;
        bits_code = c;
        bits_valid = 1'b1;
        @(posedge clk_sys); #10;
        bits_valid = 1'b0;
        bits_code = ~c; // Bus no longer holds the word
    endtask : send_bits
    // Low long enough for the pin synchroniser, then a rising start
    task automatic start_cfg;
        start_pin = 1'b0;
        repeat (3) @(posedge clk_sys);
        #10 start_pin = 1'b1;
    endtask : start_cfg
    // Done strobe for one cycle
    task automatic end_cfg;
        @(posedge clk_sys); #10 done = 1'b1;
        @(posedge clk_sys); #10 done = 1'b0;
    endtask : end_cfg
    // Encryption setting for the words that follow
    task automatic set_enc(input logic v);
        enc = v;
    endtask : set_enc
endmodule : cmcs_cfg_src

// file: testbench/cmcs_top_tb.sv
// Self-checking bench for the master clock selection block
module cmcs_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [4:0] HALF [0:11] = '{5'h10, 5'h09, 5'h07, 5'h06, 5'h05, 5'h04, 5'h04,
                                           5'h03, 5'h03, 5'h02, 5'h02, 5'h01};
    logic       clk_sys = 1'b0, resetn = 1'b0, tap_act = 1'b0, osc_en = 1'b0;
    logic [1:0] pins = 2'h0, aport;
    logic       start_pin, done, bv, enc, cmc, uclk, rej, held, tap;
    logic [3:0] bcode, ccode;
    int         fails = 0, cmp_count = 0, cyc = 0, n;
    always #50 clk_sys = ~clk_sys;
    cmcs_top u_cmcs_top (.CLK_SYS(clk_sys), .RESETN(resetn), .CFG_PORT_PINS(pins), .CFG_START_PIN(start_pin),
        .CFG_DONE(done), .CLK_BITS_VALID(bv), .CLK_BITS_CODE(bcode), .ENCRYPT_EN(enc), .TAP_ACTIVATE(tap_act),
        .USER_OSC_EN(osc_en), .CONFIG_MASTER_CLOCK(cmc), .USER_OSC_CLK(uclk), .CLOCK_CODE(ccode),
        .CLOCK_CODE_REJECT(rej), .ACTIVE_PORT(aport), .PORT_HELD(held), .TAP_ACTIVE(tap));
    cmcs_cfg_src u_cmcs_cfg_src (.clk_sys(clk_sys), .start_pin(start_pin), .done(done), .bits_valid(bv),
        .bits_code(bcode), .enc(enc));
    task automatic close_out;
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out
    // Hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            close_out();
        end
    end
    task automatic tick;
        @(posedge clk_sys); #10;
    endtask : tick
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        cmp_count++;
        if (e !== s) begin
            fails++;
            $display("FAIL %s expected %0h seen %0h", nm, e, s);
        end
    endtask : chk
    task automatic wait_lvl(input logic v);
        for (int i = 0; i < 80 && cmc !== v; i++) tick();
    endtask : wait_lvl
    // Lands just after a rising edge of the master clock, then times the high phase
    task automatic meas_high;
        wait_lvl(1'b0);
        wait_lvl(1'b1);
        n = 0;
        while (cmc === 1'b1 && n < 40) begin
            tick();
            n++;
        end
    endtask : meas_high
    task automatic t_reset;
        resetn = 1'b0;
        repeat (2) @(posedge clk_sys);
        #10 resetn = 1'b1;
        chk("reset code", 8'h0C, {4'h0, ccode});
        chk("reset tap", 8'h00, {7'h00, tap});
        meas_high();
        chk("default half", 8'd13, 8'(n));
    endtask : t_reset
    // Every selectable rate, timed in turn
    task automatic t_select;
        for (int c = 0; c < 12; c++) begin
            u_cmcs_cfg_src.send_bits(4'(c), 1'b0);
            meas_high();
            chk("code", 8'(c), {4'h0, ccode});
            chk("half", {3'h0, HALF[c]}, 8'(n));
        end
    endtask : t_select
    // Codes over the limit leave the rate alone
    task automatic t_refuse;
        u_cmcs_cfg_src.set_enc(1'b1);
        u_cmcs_cfg_src.send_bits(4'h9, 1'b1);
        chk("reject enc", 8'h01, {7'h00, rej});
        meas_high();
        chk("kept code", 8'h0B, {4'h0, ccode});
        u_cmcs_cfg_src.send_bits(4'h8, 1'b0);
        chk("reject clear", 8'h00, {7'h00, rej});
        meas_high();
        chk("enc max", 8'h08, {4'h0, ccode});
        u_cmcs_cfg_src.set_enc(1'b0);
        u_cmcs_cfg_src.send_bits(4'hF, 1'b1);
        chk("reject plain", 8'h01, {7'h00, rej});
        u_cmcs_cfg_src.send_bits(4'h0, 1'b0);
    endtask : t_refuse
    // Port latched at start, kept through a second start, freed by done
    task automatic t_port;
        pins = 2'h2;
        u_cmcs_cfg_src.start_cfg();
        for (int i = 0; i < 10 && held !== 1'b1; i++) tick();
        chk("port", 8'h02, {6'h00, aport});
        pins = 2'h1;
        u_cmcs_cfg_src.start_cfg();
        repeat (6) tick();
        chk("held", 8'h01, {7'h00, held});
        chk("port kept", 8'h02, {6'h00, aport});
        u_cmcs_cfg_src.end_cfg();
        tick();
        chk("released", 8'h00, {7'h00, held});
    endtask : t_port
    task automatic t_tap;
        tap_act = 1'b1;
        tick();
        tap_act = 1'b0;
        repeat (3) tick();
        chk("tap", 8'h01, {7'h00, tap});
    endtask : t_tap
    // Oscillator copied to the user tree while gated on
    task automatic t_user;
        osc_en = 1'b1;
        meas_high();
        meas_high();
        for (int i = 0; i < 32; i++) begin
            chk("user clk", {7'h00, cmc}, {7'h00, uclk});
            tick();
        end
        osc_en = 1'b0;
        meas_high();
        wait_lvl(1'b0);
        wait_lvl(1'b1);
        chk("user off", 8'h00, {7'h00, uclk});
    endtask : t_user
    initial begin
        t_reset();
        t_select();
        t_refuse();
        t_port();
        t_tap();
        t_user();
        t_reset();
        close_out();
    end
endmodule : cmcs_top_tb
